// File: logic/upr_pkg.sv
/*
  Shared constants and types for the USB port routing and power block:
  register offsets and field positions, port modes, pin bit positions,
  reset values and the low-power state type.
  Assumes a 32-bit APB register bus with byte addresses and three cores
  numbered host 1 = 0, host 2 = 1, on-the-go = 2.
*/
package upr_pkg;

  localparam int UPR_NUM_CORES = 3;
  localparam int UPR_PIN_W = 11;
  localparam int UPR_CORE_HOST1 = 0;
  localparam int UPR_CORE_HOST2 = 1;
  localparam int UPR_CORE_OTG = 2;

  // Clock figures, for reference by the bench
  localparam int UPR_CLK_MHZ = 125;
  localparam int UPR_LP_CLK_KHZ = 32;

  // Register map
  localparam logic [11:0] UPR_USB_PORT_CONTROL_REGISTER_OFFSET = 12'h000;
  localparam logic [11:0] UPR_STATUS_OFFSET = 12'h004;
  localparam int UPR_CTRL_BYPASS_BIT = 0;
  localparam int UPR_CTRL_MODE_LSB = 4;
  localparam int UPR_CTRL_MODE_STRIDE = 4;
  localparam int UPR_CTRL_LS_LSB = 16;
  localparam int UPR_STAT_BYPASS_BIT = 0;
  localparam int UPR_STAT_PWR_LSB = 8;
  localparam int UPR_STAT_PWR_STRIDE = 4;
  localparam int UPR_STAT_SUSP_OFS = 2;
  localparam int UPR_STAT_CLKEN_OFS = 3;

  // Port modes
  localparam logic [1:0] UPR_MODE_SERIAL = 2'h0;
  localparam logic [1:0] UPR_MODE_TRANSCEIVERLESS = 2'h1;
  localparam logic [1:0] UPR_MODE_ULPI = 2'h2;

  // Reset values
  localparam logic [1:0] UPR_MODE_RESET = UPR_MODE_SERIAL;
  localparam logic UPR_LS_RESET = 1'b0;
  localparam logic UPR_BYPASS_RESET = 1'b0;

  // Pin bit positions within one port
  localparam int UPR_PIN_VP = 0;
  localparam int UPR_PIN_VM = 1;
  localparam int UPR_PIN_OE_N = 2;
  localparam int UPR_PIN_PEER_OE_N = 2;
  localparam int UPR_PIN_RCV = 3;
  localparam int UPR_PIN_PEER_VP = 4;
  localparam int UPR_PIN_PEER_VM = 5;
  localparam int UPR_PIN_ULPI_DATA_LSB = 0;
  localparam int UPR_PIN_ULPI_STP = 8;
  localparam int UPR_PIN_ULPI_DIR = 9;
  localparam int UPR_PIN_ULPI_NXT = 10;

  // Low-power timing, in 32 kHz ticks
  localparam int UPR_SETTLE_TICKS = 2;
  localparam int UPR_TICK_CNT_W = 4;

  localparam logic [1:0] UPR_HTRANS_IDLE = 2'h0;

  typedef enum logic [1:0] {
    UPR_PWR_ACTIVE,
    UPR_PWR_XCVR_SUSPEND,
    UPR_PWR_CLK_STOPPED,
    UPR_PWR_WAKING
  } upr_pwr_state_type;

endpackage

// File: logic/upr_power_ctrl.sv
/*
  Low-power controller for one USB core: suspends the transceiver, then
  stops the core clock, and wakes on bus activity seen at 32 kHz ticks.
  Assumes lp_tick is a one-cycle pulse per low-power clock period, made
  from a synchronised clock, and line_active from synchronised pins.
*/
`timescale 1ns/100ps
module upr_power_ctrl #(
  parameter int SETTLE_TICKS = upr_pkg::UPR_SETTLE_TICKS,
  parameter int CNT_W = upr_pkg::UPR_TICK_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic lp_tick,
  input wire logic suspend_req,
  input wire logic line_active,
  output logic xcvr_suspend,
  output logic core_clk_en,
  output logic wakeup,
  output upr_pkg::upr_pwr_state_type state
);

  typedef struct packed {
    upr_pkg::upr_pwr_state_type state;
    logic [CNT_W-1:0] cnt;
  } upr_pwr_regs_type;

  upr_pwr_regs_type r;
  upr_pwr_regs_type next_r;

  always_comb begin
    next_r = r;
    unique case (r.state)
      upr_pkg::UPR_PWR_ACTIVE: begin
        if (suspend_req && !line_active) begin
          next_r.state = upr_pkg::UPR_PWR_XCVR_SUSPEND;
          next_r.cnt = '0;
        end
      end
      upr_pkg::UPR_PWR_XCVR_SUSPEND: begin
        if (!suspend_req || line_active) begin
          next_r.state = upr_pkg::UPR_PWR_ACTIVE;
        end else if (lp_tick) begin
          // Clock stops only after the transceiver has sat in suspend
          if (r.cnt == CNT_W'(SETTLE_TICKS - 1)) begin
            next_r.state = upr_pkg::UPR_PWR_CLK_STOPPED;
          end else begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end
      end
      upr_pkg::UPR_PWR_CLK_STOPPED: begin
        // Only the low-power tick is trusted here, the core is frozen
        if (lp_tick && (line_active || !suspend_req)) begin
          next_r.state = upr_pkg::UPR_PWR_WAKING;
        end
      end
      upr_pkg::UPR_PWR_WAKING: begin
        if (!suspend_req) begin
          next_r.state = upr_pkg::UPR_PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{state: upr_pkg::UPR_PWR_ACTIVE, cnt: '0};
    end else begin
      r <= next_r;
    end
  end

  assign xcvr_suspend = (r.state == upr_pkg::UPR_PWR_XCVR_SUSPEND) ||
                        (r.state == upr_pkg::UPR_PWR_CLK_STOPPED);
  assign core_clk_en = (r.state != upr_pkg::UPR_PWR_CLK_STOPPED);
  assign wakeup = (r.state == upr_pkg::UPR_PWR_WAKING);
  assign state = r.state;

endmodule

// File: logic/upr_usb_port_routing_power.sv
/*
  Port routing and power wrapper around three USB cores: per-port choice
  of serial transceiver, transceiverless emulation or ULPI, bypass from
  the on-the-go port to host port 1, per-core low-power control, an APB
  register slave and a shared AHB master for the cores' DMA.
  Assumes the cores run on clk, pins are asynchronous to clk, and the
  32 kHz low-power clock arrives on a pin and keeps running.
*/
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
// Summary of operation
// - Normally each core connects only to its own port, never another port.
// - Transceiverless mode is accepted only on host ports 1 and 2.
// - Transceiverless mode emulates two back-to-back transceivers between core and peer.
// - Host 1 is full/low speed only; host 2 and on-the-go reach high speed.
// - Each port is set for high speed and/or full/low speed signalling.
// - Host 2 takes ULPI, serial or transceiverless; on-the-go always uses an external transceiver.
// - ULPI mode puts a ULPI interface on the port pins.
// - Bypass only when on-the-go is serial and host port 1 is transceiverless.
// - Setting the bypass bit in the control register starts bypass.
// - In bypass the on-the-go transceiver is routed to the host port 1 peer.
// - In bypass the on-the-go and host 1 cores lose their ports.
// - Each core has its own power controller ticking on the 32 kHz clock.
// - Idle bus: transceiver suspends first, then the core clock stops.
// - The 32 kHz clock keeps running to catch wake-up activity.
// - Registers over APB, data buffers over an AHB master.
`timescale 1ns/100ps
module upr_usb_port_routing_power #(
  parameter int SETTLE_TICKS = upr_pkg::UPR_SETTLE_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic lp_clk_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] core_tx_vp,
  input wire logic [2:0] core_tx_vm,
  input wire logic [2:0] core_tx_oe_n,
  output logic [2:0] core_rx_vp,
  output logic [2:0] core_rx_vm,
  output logic [2:0] core_rx_rcv,
  input wire logic [2:1][7:0] core_ulpi_tx_data,
  input wire logic [2:1] core_ulpi_stp,
  output logic [2:1][7:0] core_ulpi_rx_data,
  output logic [2:1] core_ulpi_dir,
  output logic [2:1] core_ulpi_nxt,
  input wire logic [2:0] core_suspend_req,
  output logic [2:0] core_clk_en,
  output logic [2:0] core_wakeup,
  output logic [2:0] port_xcvr_suspend,
  input wire logic [2:0][10:0] port_pin_in,
  output logic [2:0][10:0] port_pin_out,
  output logic [2:0][10:0] port_pin_oe_n,
  input wire logic [2:0][1:0] core_htrans,
  input wire logic [2:0][31:0] core_haddr,
  input wire logic [2:0] core_hwrite,
  input wire logic [2:0][2:0] core_hsize,
  input wire logic [2:0][2:0] core_hburst,
  input wire logic [2:0][31:0] core_hwdata,
  output logic [2:0] core_hready,
  output logic [2:0] core_hresp,
  output logic [31:0] core_hrdata,
  output logic [1:0] htrans,
  output logic [31:0] haddr,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp
);

  localparam int NC = upr_pkg::UPR_NUM_CORES;
  localparam int PW = upr_pkg::UPR_PIN_W;
  localparam int H1 = upr_pkg::UPR_CORE_HOST1;
  localparam int OTG = upr_pkg::UPR_CORE_OTG;
  localparam int VP = upr_pkg::UPR_PIN_VP;
  localparam int VM = upr_pkg::UPR_PIN_VM;
  localparam int OEN = upr_pkg::UPR_PIN_OE_N;
  localparam int POEN = upr_pkg::UPR_PIN_PEER_OE_N;
  localparam int RCV = upr_pkg::UPR_PIN_RCV;
  localparam int PVP = upr_pkg::UPR_PIN_PEER_VP;
  localparam int PVM = upr_pkg::UPR_PIN_PEER_VM;
  localparam int UDL = upr_pkg::UPR_PIN_ULPI_DATA_LSB;
  localparam logic [1:0] M_SER = upr_pkg::UPR_MODE_SERIAL;
  localparam logic [1:0] M_TLESS = upr_pkg::UPR_MODE_TRANSCEIVERLESS;
  localparam logic [1:0] M_ULPI = upr_pkg::UPR_MODE_ULPI;

  typedef struct packed {
    logic [NC-1:0][PW-1:0] pin_meta;
    logic [NC-1:0][PW-1:0] pin_sync;
    logic lp_meta;
    logic lp_sync;
    logic lp_prev;
    logic bypass_req;
    logic [NC-1:0][1:0] mode;
    logic [NC-1:0] low_speed;
    logic [31:0] prdata;
    logic [NC-1:0][PW-1:0] pin_out;
    logic [NC-1:0][PW-1:0] pin_oe_n;
    logic [NC-1:0] rx_vp;
    logic [NC-1:0] rx_vm;
    logic [NC-1:0] rx_rcv;
    logic [2:1][7:0] ulpi_rx_data;
    logic [2:1] ulpi_dir;
    logic [2:1] ulpi_nxt;
    logic [1:0] ahb_owner;
    logic ahb_data_pending;
  } upr_state_type;

  localparam upr_state_type STATE_RESET = '{
    pin_oe_n: '1,
    bypass_req: upr_pkg::UPR_BYPASS_RESET,
    mode: {NC{upr_pkg::UPR_MODE_RESET}},
    low_speed: {NC{upr_pkg::UPR_LS_RESET}},
    default: '0
  };

  upr_state_type r;
  upr_state_type next_r;

  logic lp_tick;
  logic bypass_active;
  logic ctrl_hit;
  logic stat_hit;
  logic [31:0] rd_word;
  logic [NC-1:0] line_active;
  logic [1:0] ahb_pick;
  logic ahb_any;
  upr_pkg::upr_pwr_state_type pwr_state [NC];

  // Edge of the synchronised 32 kHz clock; the first stage is never read here
  assign lp_tick = r.lp_sync & ~r.lp_prev;

  assign bypass_active = r.bypass_req &&
                         (r.mode[OTG] == M_SER) &&
                         (r.mode[H1] == M_TLESS);

  assign ctrl_hit = (paddr == upr_pkg::UPR_USB_PORT_CONTROL_REGISTER_OFFSET);
  assign stat_hit = (paddr == upr_pkg::UPR_STATUS_OFFSET);

  // Register read view
  always_comb begin
    rd_word = '0;
    if (ctrl_hit) begin
      rd_word[upr_pkg::UPR_CTRL_BYPASS_BIT] = r.bypass_req;
      for (int i = 0; i < NC; i++) begin
        rd_word[upr_pkg::UPR_CTRL_MODE_LSB + upr_pkg::UPR_CTRL_MODE_STRIDE * i +: 2] = r.mode[i];
        rd_word[upr_pkg::UPR_CTRL_LS_LSB + i] = r.low_speed[i];
      end
    end else if (stat_hit) begin
      rd_word[upr_pkg::UPR_STAT_BYPASS_BIT] = bypass_active;
      for (int i = 0; i < NC; i++) begin
        rd_word[upr_pkg::UPR_STAT_PWR_LSB + upr_pkg::UPR_STAT_PWR_STRIDE * i +: 2] = pwr_state[i];
        rd_word[upr_pkg::UPR_STAT_PWR_LSB + upr_pkg::UPR_STAT_PWR_STRIDE * i
                + upr_pkg::UPR_STAT_SUSP_OFS] = port_xcvr_suspend[i];
        rd_word[upr_pkg::UPR_STAT_PWR_LSB + upr_pkg::UPR_STAT_PWR_STRIDE * i
                + upr_pkg::UPR_STAT_CLKEN_OFS] = core_clk_en[i];
      end
    end
  end

  // Lowest core number wins the DMA bus
  always_comb begin
    ahb_any = 1'b0;
    ahb_pick = r.ahb_owner;
    for (int i = NC - 1; i >= 0; i--) begin
      if (core_htrans[i] != upr_pkg::UPR_HTRANS_IDLE) begin
        ahb_any = 1'b1;
        ahb_pick = 2'(i);
      end
    end
  end

  // Line activity as each power controller should judge it
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      if (r.mode[i] == M_ULPI) begin
        line_active[i] = r.pin_sync[i][upr_pkg::UPR_PIN_ULPI_DIR];
      end else begin
        line_active[i] = (r.rx_vp[i] != ~r.low_speed[i]) || (r.rx_vm[i] != r.low_speed[i]);
      end
    end
    if (bypass_active) begin
      line_active[H1] = 1'b0;
      line_active[OTG] = 1'b0;
    end
  end

  always_comb begin
    next_r = r;
    next_r.pin_meta = port_pin_in;
    next_r.pin_sync = r.pin_meta;
    next_r.lp_meta = lp_clk_pin;
    next_r.lp_sync = r.lp_meta;
    next_r.lp_prev = r.lp_sync;

    // Register writes land at the access edge; illegal modes are dropped
    if (psel && penable && pwrite && ctrl_hit) begin
      next_r.bypass_req = pwdata[upr_pkg::UPR_CTRL_BYPASS_BIT];
      for (int i = 0; i < NC; i++) begin
        logic [1:0] m;
        m = pwdata[upr_pkg::UPR_CTRL_MODE_LSB + upr_pkg::UPR_CTRL_MODE_STRIDE * i +: 2];
        if ((m == M_SER) ||
            ((m == M_TLESS) && (i != OTG)) ||
            ((m == M_ULPI) && (i != H1))) begin
          next_r.mode[i] = m;
        end
        next_r.low_speed[i] = pwdata[upr_pkg::UPR_CTRL_LS_LSB + i];
      end
    end
    if (psel && !penable) begin
      next_r.prdata = rd_word;
    end

    // Each core to its own port only
    for (int p = 0; p < NC; p++) begin
      next_r.pin_out[p] = '0;
      next_r.pin_oe_n[p] = '1;
      next_r.rx_vp[p] = 1'b0;
      next_r.rx_vm[p] = 1'b0;
      next_r.rx_rcv[p] = 1'b0;
      unique case (r.mode[p])
        M_SER: begin
          // No on-the-go lines: such a transceiver is managed out of band
          next_r.pin_out[p][VP] = core_tx_vp[p];
          next_r.pin_out[p][VM] = core_tx_vm[p];
          next_r.pin_oe_n[p][VP] = core_tx_oe_n[p];
          next_r.pin_oe_n[p][VM] = core_tx_oe_n[p];
          next_r.pin_out[p][OEN] = core_tx_oe_n[p];
          next_r.pin_oe_n[p][OEN] = 1'b0;
          next_r.rx_vp[p] = r.pin_sync[p][VP];
          next_r.rx_vm[p] = r.pin_sync[p][VM];
          next_r.rx_rcv[p] = r.pin_sync[p][RCV];
        end
        M_TLESS: begin
          next_r.pin_oe_n[p][VP] = 1'b0;
          next_r.pin_oe_n[p][VM] = 1'b0;
          next_r.pin_oe_n[p][RCV] = 1'b0;
          if (!core_tx_oe_n[p]) begin
            // Core transmits: peer and core both see the core's line state
            next_r.pin_out[p][VP] = core_tx_vp[p];
            next_r.pin_out[p][VM] = core_tx_vm[p];
            next_r.pin_out[p][RCV] = core_tx_vp[p];
            next_r.rx_vp[p] = core_tx_vp[p];
            next_r.rx_vm[p] = core_tx_vm[p];
            next_r.rx_rcv[p] = core_tx_vp[p];
          end else if (!r.pin_sync[p][POEN]) begin
            next_r.pin_out[p][VP] = r.pin_sync[p][PVP];
            next_r.pin_out[p][VM] = r.pin_sync[p][PVM];
            next_r.pin_out[p][RCV] = r.pin_sync[p][PVP];
            next_r.rx_vp[p] = r.pin_sync[p][PVP];
            next_r.rx_vm[p] = r.pin_sync[p][PVM];
            next_r.rx_rcv[p] = r.pin_sync[p][PVP];
          end else begin
            // Nobody drives: emulate the pull-up idle state for the set speed
            next_r.pin_out[p][VP] = ~r.low_speed[p];
            next_r.pin_out[p][VM] = r.low_speed[p];
            next_r.pin_out[p][RCV] = ~r.low_speed[p];
            next_r.rx_vp[p] = ~r.low_speed[p];
            next_r.rx_vm[p] = r.low_speed[p];
            next_r.rx_rcv[p] = ~r.low_speed[p];
          end
        end
        M_ULPI: begin
        end
        default: begin
        end
      endcase
    end

    // ULPI on the two ports able to carry it
    for (int p = 1; p < NC; p++) begin
      next_r.ulpi_rx_data[p] = '0;
      next_r.ulpi_dir[p] = 1'b0;
      next_r.ulpi_nxt[p] = 1'b0;
      if (r.mode[p] == M_ULPI) begin
        // Turnaround follows the synchronised dir, three cycles after the dir pin
        next_r.pin_out[p][UDL +: 8] = core_ulpi_tx_data[p];
        next_r.pin_oe_n[p][UDL +: 8] = {8{r.pin_sync[p][upr_pkg::UPR_PIN_ULPI_DIR]}};
        next_r.pin_out[p][upr_pkg::UPR_PIN_ULPI_STP] = core_ulpi_stp[p];
        next_r.pin_oe_n[p][upr_pkg::UPR_PIN_ULPI_STP] = 1'b0;
        next_r.ulpi_rx_data[p] = r.pin_sync[p][UDL +: 8];
        next_r.ulpi_dir[p] = r.pin_sync[p][upr_pkg::UPR_PIN_ULPI_DIR];
        next_r.ulpi_nxt[p] = r.pin_sync[p][upr_pkg::UPR_PIN_ULPI_NXT];
      end
    end

    // Bypass: on-the-go transceiver talks straight to the host port 1 peer
    if (bypass_active) begin
      next_r.pin_out[OTG][VP] = r.pin_sync[H1][PVP];
      next_r.pin_out[OTG][VM] = r.pin_sync[H1][PVM];
      next_r.pin_oe_n[OTG][VP] = r.pin_sync[H1][POEN];
      next_r.pin_oe_n[OTG][VM] = r.pin_sync[H1][POEN];
      next_r.pin_out[OTG][OEN] = r.pin_sync[H1][POEN];
      next_r.pin_oe_n[OTG][OEN] = 1'b0;
      if (!r.pin_sync[H1][POEN]) begin
        next_r.pin_out[H1][VP] = r.pin_sync[H1][PVP];
        next_r.pin_out[H1][VM] = r.pin_sync[H1][PVM];
        next_r.pin_out[H1][RCV] = r.pin_sync[H1][PVP];
      end else begin
        next_r.pin_out[H1][VP] = r.pin_sync[OTG][VP];
        next_r.pin_out[H1][VM] = r.pin_sync[OTG][VM];
        next_r.pin_out[H1][RCV] = r.pin_sync[OTG][RCV];
      end
      next_r.rx_vp[H1] = 1'b0;
      next_r.rx_vm[H1] = 1'b0;
      next_r.rx_rcv[H1] = 1'b0;
      next_r.rx_vp[OTG] = 1'b0;
      next_r.rx_vm[OTG] = 1'b0;
      next_r.rx_rcv[OTG] = 1'b0;
    end

    // Ownership moves only with no data phase open, costing one idle cycle
    if (hready) begin
      next_r.ahb_data_pending = core_htrans[r.ahb_owner][1];
      if (!r.ahb_data_pending && !core_htrans[r.ahb_owner][1] && ahb_any) begin
        next_r.ahb_owner = ahb_pick;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  for (genvar g = 0; g < NC; g++) begin : g_pwr
    upr_power_ctrl #(
      .SETTLE_TICKS(SETTLE_TICKS),
      .CNT_W(upr_pkg::UPR_TICK_CNT_W)
    ) u_pwr (
      .clk(clk),
      .rstn(rstn),
      .lp_tick(lp_tick),
      .suspend_req(core_suspend_req[g]),
      .line_active(line_active[g]),
      .xcvr_suspend(port_xcvr_suspend[g]),
      .core_clk_en(core_clk_en[g]),
      .wakeup(core_wakeup[g]),
      .state(pwr_state[g])
    );
    assign core_hready[g] = (r.ahb_owner == 2'(g)) ? hready : 1'b0;
    assign core_hresp[g] = (r.ahb_owner == 2'(g)) ? hresp : 1'b0;
  end

  assign prdata = r.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~(ctrl_hit | stat_hit);
  assign core_rx_vp = r.rx_vp;
  assign core_rx_vm = r.rx_vm;
  assign core_rx_rcv = r.rx_rcv;
  assign core_ulpi_rx_data = r.ulpi_rx_data;
  assign core_ulpi_dir = r.ulpi_dir;
  assign core_ulpi_nxt = r.ulpi_nxt;
  assign port_pin_out = r.pin_out;
  assign port_pin_oe_n = r.pin_oe_n;
  assign core_hrdata = hrdata;
  // DMA path is a pass-through mux so cores keep AHB timing
  assign htrans = core_htrans[r.ahb_owner];
  assign haddr = core_haddr[r.ahb_owner];
  assign hwrite = core_hwrite[r.ahb_owner];
  assign hsize = core_hsize[r.ahb_owner];
  assign hburst = core_hburst[r.ahb_owner];
  assign hwdata = core_hwdata[r.ahb_owner];

endmodule

// File: testbench/upr_usb_port_routing_power_sva.sv
/*
  Checker bound to the port routing top.
  Assumes one clock and active-low async reset.
*/
`timescale 1ns/100ps
module upr_usb_port_routing_power_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] core_suspend_req,
  input wire logic [2:0] core_clk_en,
  input wire logic [2:0] core_wakeup,
  input wire logic [2:0] port_xcvr_suspend,
  input wire logic [2:0] core_hready,
  input wire logic hready,
  input wire logic [31:0] core_hrdata,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;
    s_setup ##1 s_access |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("No ready in access");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("Error outside access");
  property p_own;
    $onehot0(core_hready);
  endproperty
  a_own: assert property (p_own) else $error("Two DMA owners");
  property p_pass;
    (|core_hready) |-> hready;
  endproperty
  a_pass: assert property (p_pass) else $error("Core ready without hready");
  property p_rdata;
    core_hrdata == hrdata;
  endproperty
  a_rdata: assert property (p_rdata) else $error("DMA read data altered");
  // Clock off only while suspended
  property p_order;
    (~core_clk_en & ~port_xcvr_suspend) == 3'b000;
  endproperty
  a_order: assert property (p_order) else $error("Clock off, transceiver awake");
  property p_stop;
    (~core_clk_en & $past(core_clk_en) & ~$past(port_xcvr_suspend)) == 3'b000;
  endproperty
  a_stop: assert property (p_stop) else $error("Clock stopped before suspend");
  property p_req;
    (port_xcvr_suspend & ~$past(port_xcvr_suspend) & ~$past(core_suspend_req)) == 3'b000;
  endproperty
  a_req: assert property (p_req) else $error("Unrequested suspend");
  property p_wake;
    (core_wakeup & ~core_clk_en) == 3'b000;
  endproperty
  a_wake: assert property (p_wake) else $error("Wake with clock off");
endmodule

bind upr_usb_port_routing_power upr_usb_port_routing_power_sva u_sva (.*);

// File: testbench/upr_far_model.sv
/*
  Far side: on-board peer on port 0, serial transceivers on 1 and 2,
  ULPI direction on port 1. Assumes the bench sets the line states.
*/
`timescale 1ns/100ps
module upr_far_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic peer_en,
  input wire logic [2:0][1:0] line,
  input wire logic ulpi_dir,
  input wire logic [2:0][10:0] port_pin_out,
  input wire logic [2:0][10:0] port_pin_oe_n,
  output logic [2:0][10:0] port_pin_in
);
  logic [1:0] last;
  logic [7:0] noise;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last <= 2'h1;
      noise <= 8'h00;
    end else begin
      noise <= noise + 8'h35;
      if (peer_en) begin
        last <= line[0];
      end
    end
  end
  // No on-the-go lines: registers sit behind a side link
  always_comb begin
    port_pin_in = '0;
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 2; b++) begin
        port_pin_in[p][b] = port_pin_oe_n[p][b] ? line[p][b] : port_pin_out[p][b];
      end
      port_pin_in[p][3] = port_pin_in[p][0];
    end
    port_pin_in[0][2] = ~peer_en;
    // Released peer lines show the inverse
    port_pin_in[0][5:4] = peer_en ? line[0] : ~last;
    port_pin_in[1][9] = ulpi_dir;
    if (ulpi_dir) begin
      port_pin_in[1][7:0] = noise;
    end
  end
endmodule

// File: testbench/upr_usb_port_routing_power_tb.sv
/*
  Self-checking bench for the port routing block.
  Assumes the far model and checker are compiled with it.
*/
`timescale 1ns/100ps
module upr_usb_port_routing_power_tb;
  logic clk = 1'b0, rstn = 1'b0, lp_clk_pin = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hready = 1'b0, hresp = 1'b0, peer_en = 1'b0, ulpi_dir = 1'b0;
  logic pready, pslverr, hwrite, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, hrdata = '0, prdata, core_hrdata, haddr, hwdata, rd, ctrl;
  logic [2:0] core_tx_vp = '0, core_tx_vm = '0, core_tx_oe_n = '1, core_suspend_req = '0;
  logic [2:0] core_hwrite = '0, core_rx_vp, core_rx_vm, core_rx_rcv, core_clk_en;
  logic [2:0] core_wakeup, port_xcvr_suspend, core_hready, core_hresp, hsize, hburst;
  logic [2:1][7:0] core_ulpi_tx_data = '0, core_ulpi_rx_data;
  logic [2:1] core_ulpi_stp = '0, core_ulpi_dir, core_ulpi_nxt;
  logic [2:0][10:0] port_pin_in, port_pin_out, port_pin_oe_n;
  logic [2:0][1:0] core_htrans = '0, line = 6'h15;
  logic [1:0] htrans;
  logic [2:0][31:0] core_haddr = '0, core_hwdata = '0;
  logic [2:0][2:0] core_hsize = '0, core_hburst = '0;
  localparam logic [31:0] M = 32'h0007_3331;
  int n_fail = 0, checks = 0, cyc = 0, seed = 32'hb7e3_33e3;

  upr_usb_port_routing_power #(.SETTLE_TICKS(1)) DUT (.*);
  upr_far_model u_far (.clk(clk), .rstn(rstn), .peer_en(peer_en), .line(line),
    .ulpi_dir(ulpi_dir), .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
    .port_pin_in(port_pin_in));

  function automatic logic [31:0] exp_ctrl(input logic [31:0] old, input logic [31:0] w);
    logic [31:0] r;
    logic [1:0] m;
    r = {old[31:19], w[18:16], old[15:1], w[0]};
    for (int i = 0; i < 3; i++) begin
      m = w[4+4*i +: 2];
      if (m != 2'h3 && !(i == 0 && m == 2'h2) && !(i == 2 && m == 2'h1)) begin
        r[4+4*i +: 2] = m;
      end
    end
    return r;
  endfunction

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task results;
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [31:0] d);
    apb(1'b1, upr_pkg::UPR_USB_PORT_CONTROL_REGISTER_OFFSET, d);
    ctrl = exp_ctrl(ctrl, d);
  endtask

  task wt(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    forever #4 clk = ~clk;
  end
  // Fast low-power clock stand-in keeps the run short
  initial begin
    forever begin
      repeat (4) @(posedge clk);
      lp_clk_pin <= ~lp_clk_pin;
    end
  end
  always @(posedge clk) begin
    core_htrans <= 6'($random(seed));
    core_haddr <= {3{$random(seed)}};
    core_hwrite <= 3'($random(seed));
    core_hwdata <= {3{$random(seed)}};
    hrdata <= $random(seed);
    hready <= 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    ctrl = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, upr_pkg::UPR_STATUS_OFFSET, '0);
    chk("status reset", rd & 32'h000b_bb01, 32'h0008_8800);
    apb(1'b0, 12'h100, '0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 16; i++) begin
      wr($random(seed));
      apb(1'b0, upr_pkg::UPR_USB_PORT_CONTROL_REGISTER_OFFSET, '0);
      chk("control", rd & M, ctrl & M);
    end
    wr(32'h0000_0010);
    wt(4);
    chk("tll idle", {port_pin_out[0][1:0], port_pin_oe_n[0][1:0]}, 32'h4);
    @(posedge clk);
    core_tx_oe_n <= 3'h4;
    core_tx_vp <= 3'h2;
    core_tx_vm <= 3'h1;
    wt(3);
    chk("tll tx", {30'h0, port_pin_out[0][1:0]}, 32'h2);
    chk("host2 tx", {port_pin_out[1][1:0], port_pin_oe_n[1][1:0]}, 32'h4);
    chk("otg quiet", {30'h0, port_pin_oe_n[2][1:0]}, 32'h3);
    @(posedge clk);
    core_tx_oe_n <= 3'h7;
    peer_en <= 1'b1;
    line <= 6'h16;
    wt(5);
    chk("tll rx", {core_rx_vm[0], core_rx_vp[0]}, 32'h2);
    @(posedge clk);
    line <= 6'h15;
    wr(32'h0000_0011);
    apb(1'b0, upr_pkg::UPR_STATUS_OFFSET, '0);
    chk("bypass on", rd & 32'h1, 32'h1);
    wt(5);
    chk("bypass rx", {29'h0, core_rx_vp}, 32'h2);
    chk("bypass pins", {port_pin_out[2][1:0], port_pin_oe_n[2][1:0]}, 32'h4);
    wr(32'h0000_0001);
    apb(1'b0, upr_pkg::UPR_STATUS_OFFSET, '0);
    chk("bypass blocked", rd & 32'h1, 32'h0);
    wr(32'h0000_0010);
    wt(5);
    chk("normal rx", {29'h0, core_rx_vp}, 32'h7);
    @(posedge clk);
    core_ulpi_tx_data[1] <= 8'($random(seed));
    wr(32'h0000_0210);
    wt(4);
    chk("ulpi tx", {port_pin_out[1][7:0], port_pin_oe_n[1][7:0]}, {core_ulpi_tx_data[1], 8'h00});
    @(posedge clk);
    ulpi_dir <= 1'b1;
    wt(5);
    chk("ulpi turn", {core_ulpi_dir[1], port_pin_oe_n[1][7:0]}, 32'h1ff);
    @(posedge clk);
    ulpi_dir <= 1'b0;
    wr(32'h0000_0010);
    @(posedge clk);
    core_suspend_req[1] <= 1'b1;
    wait (port_xcvr_suspend[1] === 1'b1);
    chk("clk pre-suspend", core_clk_en, 32'h7);
    wait (core_clk_en[1] === 1'b0);
    @(negedge clk);
    chk("clock stop", {core_clk_en, port_xcvr_suspend}, 32'h2a);
    @(posedge clk);
    line[1] <= 2'h0;
    wait (core_wakeup[1] === 1'b1);
    @(negedge clk);
    chk("wake", {core_wakeup, core_clk_en}, 32'h17);
    @(posedge clk);
    core_suspend_req[1] <= 1'b0;
    line[1] <= 2'h1;
    wait (core_wakeup[1] === 1'b0);
    @(negedge clk);
    chk("awake", {core_wakeup, core_clk_en}, 32'h07);
    results();
  end
endmodule
